/* rtl/tcbu_pkg.sv */
// Constants and types for the transfer control branch unit.
// Assumes the instruction type bits have already selected the transfer control class.
package tcbu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // First instruction word fields, plus the offset MSB of the second word
   localparam int OPC_MSB = 29;
   localparam int OPC_LSB = 27;
   localparam int PHASE_MSB = 26;
   localparam int PHASE_LSB = 24;
   localparam int REL_BIT = 23;
   localparam int CARRY_BIT = 21;
   localparam int FLY_BIT = 20;
   localparam int TF_BIT = 19;
   localparam int DATA_BIT = 18;
   localparam int PHC_BIT = 17;
   localparam int WAIT_BIT = 16;
   localparam int MASK_MSB = 15;
   localparam int MASK_LSB = 8;
   localparam int VAL_MSB = 7;
   localparam int VAL_LSB = 0;
   localparam int OFS_MSB = 23;

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes
   localparam logic [2:0] OPC_JUMP = 3'h0;
   localparam logic [2:0] OPC_CALL = 3'h1;
   localparam logic [2:0] OPC_RETURN = 3'h2;
   localparam logic [2:0] OPC_INT = 3'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status register bit positions
   localparam int ISR_HALT_INT = 0;
   localparam int ISR_ILLEGAL = 1;
   localparam int ISR_FLY = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised pin vector layout
   localparam int PIN_REQ = 0;
   localparam int PIN_ATN = 1;
   localparam int PIN_PH_LSB = 2;
   localparam int PIN_PH_MSB = 4;
   localparam int PIN_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and pointer step
   localparam logic [31:0] IP_RST = 32'h0000_0000;
   localparam logic [31:0] RET_RST = 32'h0000_0000;
   localparam logic [31:0] OPND_RST = 32'h0000_0000;
   localparam logic [7:0] ISR_RST = 8'h00;
   localparam logic CARRY_RST = 1'b0;
   localparam logic [31:0] IP_STEP = 32'h0000_0008;

   typedef enum logic [2:0] {
      TCBU_IDLE,
      TCBU_LOAD,
      TCBU_WAIT,
      TCBU_EVAL,
      TCBU_HALT
   } tcbu_state_t;

endpackage

/* rtl/tcbu_cond_if.sv */
// Interface between the branch unit control and its condition evaluator.
// Assumes both ends sit on the same clock; the evaluator is purely combinational.
`timescale 1ns/1ps
interface tcbu_cond_if;
   logic [31:0] word0;
   logic carry;
   logic [2:0] phase_lat;
   logic atn;
   logic target_mode;
   logic [7:0] first_byte;
   logic taken;

   modport ctrl (output word0, output carry, output phase_lat, output atn, output target_mode,
      output first_byte, input taken);
   modport eval (input word0, input carry, input phase_lat, input atn, input target_mode,
      input first_byte, output taken);
endinterface

/* rtl/tcbu_cond.sv */
// Branch condition evaluator: carry test, phase or ATN test, masked data compare.
// Assumes all inputs are stable for the cycle in which taken is used.
`timescale 1ns/1ps
module tcbu_cond (
   tcbu_cond_if.eval cif
);
   logic phase_true;
   logic data_true;
   logic use_phase;
   logic use_data;
   logic all_true;
   logic all_false;
   logic tf;

   always_comb begin
      tf = cif.word0[tcbu_pkg::TF_BIT];
      use_phase = cif.word0[tcbu_pkg::PHC_BIT];
      use_data = cif.word0[tcbu_pkg::DATA_BIT];
      // Target mode tests ATN instead of the phase lines
      if (cif.target_mode) begin
         phase_true = cif.atn;
      end else begin
         phase_true = (cif.phase_lat == cif.word0[tcbu_pkg::PHASE_MSB:tcbu_pkg::PHASE_LSB]);
      end
      // Set mask bits exclude that bit position
      data_true = (((cif.first_byte ^ cif.word0[tcbu_pkg::VAL_MSB:tcbu_pkg::VAL_LSB])
         & ~cif.word0[tcbu_pkg::MASK_MSB:tcbu_pkg::MASK_LSB]) == 8'h00);
      all_true = (!use_phase || phase_true) && (!use_data || data_true);
      all_false = (use_phase || use_data) && (!use_phase || !phase_true) && (!use_data || !data_true);
      if (cif.word0[tcbu_pkg::CARRY_BIT]) begin
         cif.taken = (cif.carry == tf);
      end else begin
         cif.taken = tf ? all_true : all_false;
      end
   end
endmodule

/* rtl/tcbu_top.sv */
// Transfer control branch unit of the script processor: jump, call, return, interrupt.
// Assumes a fetch unit hands over both instruction words and advances the pointer itself.
// Assumes exec_word0 still stands in the cycle after exec_start, and that the
// fetch unit does not step the pointer in the evaluation cycle.
// Bus pins are asynchronous; every other input comes from logic on this clock.
// Status bits stay set until isr_clear; a set in the same cycle wins.
//
// Function
// - Bits 29-27 select jump, call, return, interrupt
// - Taken jump loads pointer from operand register
// - Not taken leaves instruction pointer unchanged
// - Taken call saves pointer, then loads operand
// - Taken return restores pointer from return register
// - Return without call is neither tracked nor flagged
// - Taken interrupt asserts irq_n, keeps operand vector
// - Halting interrupt stops; host pointer write resumes
// - Bit 20 sets on-the-fly flag, no halt
// - Phase field bits 26-24 against latched phase
// - Bit 23 adds signed offset to pointer
// - Relative mode applies to jump and call only
// - Offset is two's complement, +/-8-MB reach
// - Bit 21 branches on carry with polarity
// - Bit 19 picks branch on true or false
// - Both compares must agree to branch
// - Bit 18 compares first received byte
// - Initiator phase compare true on equal phase
// - Target mode phase compare tests ATN
// - Bit 16 waits for unserviced phase request
// - Mask bits 15-8 exclude byte bit positions
// - Compare value comes from bits 7-0
// - Carry changes only by add, set, clear
`timescale 1ns/1ps
module tcbu_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic exec_start,
   input wire logic [31:0] exec_word0,
   input wire logic [31:0] exec_word1,
   output logic exec_ready,
   output logic exec_done,
   output logic branch_taken,
   input wire logic ip_step,
   input wire logic host_ip_wr,
   input wire logic [31:0] host_ip_data,
   output logic [31:0] instruction_pointer,
   output logic [31:0] operand_holding_register,
   output logic [31:0] return_address,
   input wire logic alu_add_valid,
   input wire logic alu_add_carry,
   input wire logic alu_set_carry,
   input wire logic alu_clr_carry,
   output logic alu_carry,
   input wire logic target_mode,
   input wire logic [7:0] first_received_byte_register,
   input wire logic bus_req,
   input wire logic bus_atn,
   input wire logic [2:0] bus_phase,
   input wire logic phase_serviced,
   input wire logic [7:0] isr_clear,
   output logic [7:0] interrupt_status_register,
   output logic irq_n,
   output logic halted
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      tcbu_pkg::tcbu_state_t state;
      logic [tcbu_pkg::PIN_W-1:0] sync1;
      logic [tcbu_pkg::PIN_W-1:0] sync2;
      logic [tcbu_pkg::PIN_W-1:0] sync3;
      logic [tcbu_pkg::PIN_W-1:0] pins;
      logic [2:0] phase_lat;
      logic pending;
      logic [31:0] word0;
      logic [31:0] operand;
      logic [31:0] ip;
      logic [31:0] ret;
      logic carry;
      logic [7:0] isr;
      logic halted;
      logic done;
      logic taken;
   } tcbu_regs_t;

   tcbu_regs_t r_q;
   tcbu_regs_t r_d;

   // Carrier to the condition evaluator
   tcbu_cond_if cif ();

   // Decode helpers
   logic [2:0] opc;
   logic is_rel;
   logic [31:0] offset_ext;
   logic [31:0] target;
   logic [tcbu_pkg::PIN_W-1:0] differ;
   logic req_rise;
   logic needs_wait;
   logic [7:0] isr_set;

   ////////////////////////////////////////////////////////////////////////////
   // Condition evaluator

   assign cif.word0 = r_q.word0;
   assign cif.carry = r_q.carry;
   assign cif.phase_lat = r_q.phase_lat;
   assign cif.atn = r_q.pins[tcbu_pkg::PIN_ATN];
   assign cif.target_mode = target_mode;
   assign cif.first_byte = first_received_byte_register;

   tcbu_cond u_cond (
      .cif(cif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode and target address

   assign opc = r_q.word0[tcbu_pkg::OPC_MSB:tcbu_pkg::OPC_LSB];
   // Relative base is the pointer at evaluation, already past this instruction
   assign is_rel = r_q.word0[tcbu_pkg::REL_BIT] && (opc == tcbu_pkg::OPC_JUMP || opc == tcbu_pkg::OPC_CALL);
   assign offset_ext = {{8{r_q.operand[tcbu_pkg::OFS_MSB]}}, r_q.operand[tcbu_pkg::OFS_MSB:0]};
   assign target = is_rel ? r_q.ip + offset_ext : r_q.operand;
   // Carry tests compare neither phase nor data, so they never wait
   assign needs_wait = r_q.word0[tcbu_pkg::WAIT_BIT] && !r_q.word0[tcbu_pkg::CARRY_BIT]
      && (r_q.word0[tcbu_pkg::PHC_BIT] || r_q.word0[tcbu_pkg::DATA_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      isr_set = 8'h00;

      // Pin synchroniser: a change counts once the second and third stages agree
      r_d.sync1 = {bus_phase, bus_atn, bus_req};
      r_d.sync2 = r_q.sync1;
      r_d.sync3 = r_q.sync2;
      differ = r_q.sync2 ^ r_q.sync3;
      r_d.pins = (r_q.sync2 & ~differ) | (r_q.pins & differ);
      req_rise = r_d.pins[tcbu_pkg::PIN_REQ] && !r_q.pins[tcbu_pkg::PIN_REQ];

      // Phase lines are latched as the request asserts and stay pending until serviced or consumed by a wait
      if (phase_serviced) begin
         r_d.pending = 1'b0;
      end
      if (req_rise) begin
         r_d.phase_lat = r_d.pins[tcbu_pkg::PIN_PH_MSB:tcbu_pkg::PIN_PH_LSB];
         r_d.pending = 1'b1;
      end

      // Carry holds unless explicitly changed
      if (alu_set_carry) begin
         r_d.carry = 1'b1;
      end else if (alu_clr_carry) begin
         r_d.carry = 1'b0;
      end else if (alu_add_valid) begin
         r_d.carry = alu_add_carry;
      end

      // Fetch step; a pointer load in the evaluation cycle takes precedence
      if (ip_step) begin
         r_d.ip = r_q.ip + tcbu_pkg::IP_STEP;
      end

      case (r_q.state)
         tcbu_pkg::TCBU_IDLE: begin
            // A halted unit takes no new instruction
            if (exec_start && !r_q.halted) begin
               r_d.word0 = exec_word0;
               r_d.state = tcbu_pkg::TCBU_LOAD;
            end
         end
         tcbu_pkg::TCBU_LOAD: begin
            // Second word arrives the cycle after the first
            r_d.operand = exec_word1;
            // Reserved codes halt at once and never reach evaluation
            if (exec_word0[tcbu_pkg::OPC_MSB] && r_q.word0[tcbu_pkg::OPC_MSB]) begin
               isr_set[tcbu_pkg::ISR_ILLEGAL] = 1'b1;
               r_d.halted = 1'b1;
               r_d.done = 1'b1;
               r_d.taken = 1'b0;
               r_d.state = tcbu_pkg::TCBU_HALT;
            end else if (needs_wait) begin
               r_d.state = tcbu_pkg::TCBU_WAIT;
            end else begin
               r_d.state = tcbu_pkg::TCBU_EVAL;
            end
         end
         tcbu_pkg::TCBU_WAIT: begin
            // Consume the unserviced request; a fresh one in this cycle survives
            if (r_q.pending) begin
               r_d.pending = req_rise;
               r_d.state = tcbu_pkg::TCBU_EVAL;
            end
         end
         tcbu_pkg::TCBU_EVAL: begin
            // Every path below except a taken interrupt overrides a pointer step in this cycle
            r_d.done = 1'b1;
            r_d.taken = cif.taken;
            r_d.state = tcbu_pkg::TCBU_IDLE;
            if (cif.taken) begin
               case (opc)
                  tcbu_pkg::OPC_JUMP: begin
                     r_d.ip = target;
                  end
                  tcbu_pkg::OPC_CALL: begin
                     // Saved pointer already addresses the following instruction
                     r_d.ret = r_q.ip;
                     r_d.ip = target;
                  end
                  tcbu_pkg::OPC_RETURN: begin
                     // No call history is kept, so an unmatched return just reloads
                     r_d.ip = r_q.ret;
                  end
                  tcbu_pkg::OPC_INT: begin
                     // On the fly keeps running; otherwise stop until the host writes the pointer
                     if (r_q.word0[tcbu_pkg::FLY_BIT]) begin
                        isr_set[tcbu_pkg::ISR_FLY] = 1'b1;
                     end else begin
                        isr_set[tcbu_pkg::ISR_HALT_INT] = 1'b1;
                        r_d.halted = 1'b1;
                        r_d.state = tcbu_pkg::TCBU_HALT;
                     end
                  end
                  default: begin
                     r_d.ip = r_q.ip;
                  end
               endcase
            end else begin
               r_d.ip = r_q.ip;
            end
         end
         tcbu_pkg::TCBU_HALT: begin
            // Only a host pointer write leaves this state
            r_d.state = tcbu_pkg::TCBU_HALT;
         end
         default: begin
            r_d.state = tcbu_pkg::TCBU_IDLE;
         end
      endcase

      // Host write of the pointer restarts a halted processor
      if (host_ip_wr) begin
         r_d.ip = host_ip_data;
         r_d.halted = 1'b0;
         if (r_q.state == tcbu_pkg::TCBU_HALT) begin
            r_d.state = tcbu_pkg::TCBU_IDLE;
         end
      end

      // Sticky status: a set in the cycle of its clear wins
      r_d.isr = (r_q.isr & ~isr_clear) | isr_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Synchronous reset; the synchroniser stages clear too, so that no false
   // request edge follows reset while the pins idle low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_q.state <= tcbu_pkg::TCBU_IDLE;
         r_q.sync1 <= '0;
         r_q.sync2 <= '0;
         r_q.sync3 <= '0;
         r_q.pins <= '0;
         r_q.phase_lat <= 3'h0;
         r_q.pending <= 1'b0;
         r_q.word0 <= 32'h0000_0000;
         r_q.operand <= tcbu_pkg::OPND_RST;
         r_q.ip <= tcbu_pkg::IP_RST;
         r_q.ret <= tcbu_pkg::RET_RST;
         r_q.carry <= tcbu_pkg::CARRY_RST;
         r_q.isr <= tcbu_pkg::ISR_RST;
         r_q.halted <= 1'b0;
         r_q.done <= 1'b0;
         r_q.taken <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign exec_ready = (r_q.state == tcbu_pkg::TCBU_IDLE) && !r_q.halted;
   assign exec_done = r_q.done;
   assign branch_taken = r_q.taken;
   assign instruction_pointer = r_q.ip;
   assign operand_holding_register = r_q.operand;
   assign return_address = r_q.ret;
   assign alu_carry = r_q.carry;
   assign interrupt_status_register = r_q.isr;
   // Any unserviced status bit holds the request low until the host clears it
   assign irq_n = ~(r_q.isr[tcbu_pkg::ISR_HALT_INT] | r_q.isr[tcbu_pkg::ISR_ILLEGAL]
      | r_q.isr[tcbu_pkg::ISR_FLY]);
   assign halted = r_q.halted;

endmodule

/* sim/tcbu_sva.sv */
// Port assertions for the transfer control branch unit.
// Assumes it is bound to tcbu_top and that all ports share one clock.
`timescale 1ns/1ps
module tcbu_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic exec_start,
   input wire logic exec_ready,
   input wire logic [31:0] exec_word0,
   input wire logic [31:0] exec_word1,
   input wire logic exec_done,
   input wire logic branch_taken,
   input wire logic host_ip_wr,
   input wire logic [31:0] host_ip_data,
   input wire logic [31:0] instruction_pointer,
   input wire logic [31:0] operand_holding_register,
   input wire logic [31:0] return_address,
   input wire logic alu_add_valid,
   input wire logic alu_set_carry,
   input wire logic alu_clr_carry,
   input wire logic alu_carry,
   input wire logic [7:0] interrupt_status_register,
   input wire logic irq_n,
   input wire logic halted
);
   logic [31:0] w0_q, w1_q, ip_q, ret_q;
   logic s_q;
   wire logic strt = exec_start && exec_ready;
   wire logic [2:0] op = w0_q[tcbu_pkg::OPC_MSB:tcbu_pkg::OPC_LSB];
   wire logic tk = exec_done && branch_taken;
   wire logic rel = w0_q[tcbu_pkg::REL_BIT];
   wire logic fly = w0_q[tcbu_pkg::FLY_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot of the instruction in flight
   always_ff @(posedge clk) begin
      s_q <= strt;
      if (strt) begin
         w0_q <= exec_word0;
         ip_q <= instruction_pointer;
         ret_q <= return_address;
      end
      if (s_q) begin
         w1_q <= exec_word1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_start_done: assert property (strt |-> ##[2:60] exec_done) else $error("no done");
   a_halt_refuse: assert property (halted |-> !exec_ready) else $error("ready while halted");
   a_jump_abs: assert property (tk && op == tcbu_pkg::OPC_JUMP && !rel |-> instruction_pointer == w1_q)
      else $error("jump target");
   a_call_save: assert property (tk && op == tcbu_pkg::OPC_CALL |-> return_address == ip_q)
      else $error("call save");
   a_rel_target: assert property (tk && op[2:1] == 2'h0 && rel |->
      instruction_pointer == ip_q + {{8{w1_q[23]}}, w1_q[23:0]}) else $error("relative target");
   a_ret_restore: assert property (tk && op == tcbu_pkg::OPC_RETURN |-> instruction_pointer == ret_q)
      else $error("return target");
   a_hold_ip: assert property (exec_done && !branch_taken && !op[2] |-> instruction_pointer == ip_q)
      else $error("pointer moved");
   a_int_vector: assert property (tk && op == tcbu_pkg::OPC_INT |->
      operand_holding_register == w1_q && !irq_n) else $error("interrupt vector");
   a_int_halt: assert property (tk && op == tcbu_pkg::OPC_INT && !fly |=> halted) else $error("no halt");
   a_int_fly: assert property (tk && op == tcbu_pkg::OPC_INT && fly |->
      !halted && interrupt_status_register[tcbu_pkg::ISR_FLY]) else $error("fly flag");
   a_illegal_op: assert property (strt && exec_word0[29] |-> ##2 exec_done ##1
      (halted && interrupt_status_register[tcbu_pkg::ISR_ILLEGAL])) else $error("illegal op");
   a_host_wr: assert property (host_ip_wr |=> instruction_pointer == $past(host_ip_data) && !halted)
      else $error("host write");
   a_carry_hold: assert property (!(alu_add_valid || alu_set_carry || alu_clr_carry) |=>
      $stable(alu_carry)) else $error("carry moved");
   c_wait: cover property (strt && exec_word0[tcbu_pkg::WAIT_BIT] ##3 !exec_ready);
   c_call: cover property (tk && op == tcbu_pkg::OPC_CALL);
   c_fly: cover property (tk && op == tcbu_pkg::OPC_INT && fly);
   c_illegal: cover property (halted && interrupt_status_register[tcbu_pkg::ISR_ILLEGAL]);
endmodule

/* sim/tcbu_bus_peer.sv */
// Bus peer model: drives phase lines, then a request strobe, and the ATN level.
// Assumes the bench pulses go for one cycle and waits for the frame to end.
`timescale 1ns/1ps
module tcbu_bus_peer (
   input wire logic clk,
   input wire logic go,
   input wire logic [2:0] phase_in,
   input wire logic atn_in,
   output logic bus_req,
   output logic [2:0] bus_phase,
   output logic bus_atn
);
   int cnt = 0;
   logic go_s = 1'h0;
   logic atn_s = 1'h0;
   logic [2:0] ph_s = 3'h0;
   initial begin
      bus_req = 1'h0;
      bus_phase = 3'h0;
      bus_atn = 1'h0;
   end
   always @(posedge clk) begin
      // Bench inputs are taken at the edge, before they move 1 ns later
      go_s = go;
      atn_s = atn_in;
      ph_s = phase_in;
      #1;
      bus_atn = atn_s;
      if (go_s && cnt == 0) begin
         bus_phase = ph_s;
         cnt = 1;
      end else if (cnt != 0) begin
         // Phase settles before the request rises
         cnt = cnt + 1;
         bus_req = (cnt >= 3 && cnt < 9);
         if (cnt == 12) begin
            cnt = 0;
         end
      end
   end
endmodule

/* sim/tcbu_top_tb.sv */
// Bench for the branch unit: runs instructions and checks pointer, flags and status.
// Assumes the bus peer model and the bound checker.
`timescale 1ns/1ps
module tcbu_top_tb;
   logic clk = '0, rst_n = '0, exec_start = '0, ip_step = '0, host_ip_wr = '0, alu_add_valid = '0;
   logic alu_add_carry = '0, alu_set_carry = '0, alu_clr_carry = '0, target_mode = '0, phase_serviced = '0;
   logic go = '0, atn_in = '0;
   logic [2:0] phase_in = '0;
   logic [7:0] first_received_byte_register = '0, isr_clear = '0;
   logic [31:0] exec_word0 = '0, exec_word1 = '0, host_ip_data = '0;
   logic exec_ready, exec_done, branch_taken, alu_carry, irq_n, halted, bus_req, bus_atn;
   logic [2:0] bus_phase;
   logic [7:0] interrupt_status_register;
   logic [31:0] instruction_pointer, operand_holding_register, return_address;
   int bad_count = 0;
   int total_checks = 0;
   tcbu_top u_tcbu_top (.*);
   tcbu_bus_peer u_tcbu_bus_peer (.*);
   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
      tick(1);
   endtask
   task automatic run(input logic [31:0] w0, input logic [31:0] w1);
      int k;
      exec_word0 = w0;
      exec_word1 = w1;
      exec_start = 1'h1;
      tick(1);
      exec_start = 1'h0;
      k = 0;
      while (exec_done !== 1'h1 && k < 200) begin
         tick(1);
         k++;
      end
      chk(exec_done, 1'h1, "done");
   endtask
   task automatic br(input logic [31:0] w0, input logic [31:0] w1, input logic tk, input logic [31:0] ip);
      run(w0, w1);
      chk(branch_taken, tk, "taken");
      chk(instruction_pointer, ip, "pointer");
   endtask
   task automatic bus(input logic [2:0] ph, input logic atn);
      phase_in = ph;
      atn_in = atn;
      go = 1'h1;
      tick(1);
      go = 1'h0;
      tick(16);
   endtask
   task automatic recover(input logic [31:0] ip);
      host_ip_data = ip;
      pulse(host_ip_wr);
      chk(instruction_pointer, ip, "host pointer");
      chk(halted, 1'h0, "resumed");
      isr_clear = 8'hFF;
      tick(1);
      isr_clear = 8'h00;
      tick(1);
      chk(irq_n, 1'h1, "irq cleared");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      rst_n = 1'h1;
      br(32'h9008_0000, 32'h0, 1'h1, 32'h0);
      chk(irq_n, 1'h1, "irq_n");
      br(32'h8008_0000, 32'h0000_0100, 1'h1, 32'h0000_0100);
      chk(operand_holding_register, 32'h0000_0100, "operand");
      br(32'h8000_0000, 32'h0000_0800, 1'h0, 32'h0000_0100);
      br(32'h8808_0000, 32'h0000_0200, 1'h1, 32'h0000_0200);
      chk(return_address, 32'h0000_0100, "return");
      br(32'h9088_0000, 32'h0000_0040, 1'h1, 32'h0000_0100);
      br(32'h8088_0000, 32'h00FF_FFF0, 1'h1, 32'h0000_00F0);
      br(32'h8888_0000, 32'h0000_0010, 1'h1, 32'h0000_0100);
      pulse(alu_set_carry);
      br(32'h8028_0000, 32'h0000_0300, 1'h1, 32'h0000_0300);
      br(32'h8020_0000, 32'h0000_0400, 1'h0, 32'h0000_0300);
      pulse(alu_clr_carry);
      br(32'h8028_0000, 32'h0000_0400, 1'h0, 32'h0000_0300);
      alu_add_carry = 1'h1;
      pulse(alu_add_valid);
      chk(alu_carry, 1'h1, "carry");
      first_received_byte_register = 8'h85;
      br(32'h800C_7F80, 32'h0000_0500, 1'h1, 32'h0000_0500);
      first_received_byte_register = 8'h05;
      br(32'h800C_7F80, 32'h0000_0600, 1'h0, 32'h0000_0500);
      for (int i = 0; i < 8; i++) begin
         bus(3'(i), 1'h0);
         br({5'h10, 3'(i), 24'h0A_0000}, 32'h0000_0600, 1'h1, 32'h0000_0600);
         br({5'h10, 3'(i) ^ 3'h1, 24'h0A_0000}, 32'h0000_0700, 1'h0, 32'h0000_0600);
      end
      br(32'h8006_0011, 32'h0000_0700, 1'h1, 32'h0000_0700);
      br(32'h8706_0011, 32'h0000_0800, 1'h0, 32'h0000_0700);
      br(32'h870E_0011, 32'h0000_0800, 1'h0, 32'h0000_0700);
      pulse(phase_serviced);
      fork
         br(32'h830B_0000, 32'h0000_0800, 1'h1, 32'h0000_0800);
         begin
            tick(8);
            chk(exec_ready, 1'h0, "waiting");
            bus(3'h3, 1'h0);
         end
      join
      target_mode = 1'h1;
      atn_in = 1'h1;
      tick(6);
      br(32'h800A_0000, 32'h0000_0900, 1'h1, 32'h0000_0900);
      atn_in = 1'h0;
      tick(6);
      br(32'h800A_0000, 32'h0000_0A00, 1'h0, 32'h0000_0900);
      target_mode = 1'h0;
      br(32'h9898_0000, 32'h0000_CAFE, 1'h1, 32'h0000_0900);
      chk(operand_holding_register, 32'h0000_CAFE, "vector");
      chk(interrupt_status_register[2], 1'h1, "fly flag");
      chk(irq_n, 1'h0, "irq_n");
      chk(halted, 1'h0, "fly no halt");
      recover(32'h0000_0900);
      br(32'h9808_0000, 32'h0000_BEEF, 1'h1, 32'h0000_0900);
      tick(1);
      chk(halted, 1'h1, "halted");
      chk(interrupt_status_register[0], 1'h1, "halt flag");
      chk(irq_n, 1'h0, "irq_n halt");
      pulse(exec_start);
      tick(4);
      chk(exec_ready, 1'h0, "refused");
      // Mid-run reset from a halted state with status, carry and return set
      rst_n = 1'h0;
      tick(2);
      chk(instruction_pointer, tcbu_pkg::IP_RST, "reset pointer");
      chk(return_address, tcbu_pkg::RET_RST, "reset return");
      chk(operand_holding_register, tcbu_pkg::OPND_RST, "reset operand");
      chk(interrupt_status_register, tcbu_pkg::ISR_RST, "reset status");
      chk(alu_carry, tcbu_pkg::CARRY_RST, "reset carry");
      chk(halted, 1'h0, "reset halt");
      chk(exec_ready, 1'h1, "reset ready");
      chk(irq_n, 1'h1, "reset irq_n");
      rst_n = 1'h1;
      recover(32'h0000_0A00);
      for (int op = 4; op < 8; op++) begin
         run(32'h8000_0000 | (32'(op) << 27), 32'h0);
         tick(1);
         chk(halted, 1'h1, "illegal halt");
         chk(interrupt_status_register[1], 1'h1, "illegal flag");
         recover(32'h0000_0A00);
      end
      pulse(ip_step);
      chk(instruction_pointer, 32'h0000_0A00 + tcbu_pkg::IP_STEP, "step");
      report_and_stop();
   end
   initial begin
      #200000;
      bad_count++;
      report_and_stop();
   end
endmodule
bind tcbu_top tcbu_sva u_tcbu_sva (.*);
